// [rtl/sbp_pkg.sv]
// Shared constants and types for the serial boot PROM read logic
package sbp_pkg;

  // Storage organisation
  localparam int WORD_W = 8;
  localparam int NUM_WORDS = 64;
  localparam int FIFO_DEPTH = 32;

  // Reset-pin polarity option values
  localparam logic POL_HIGH_CLEARS = 1'b0;
  localparam logic POL_LOW_CLEARS = 1'b1;

  // Read sequence; Gray codes along clear, read, passed
  typedef enum logic [1:0] {
    SBP_CLEAR = 2'b00,
    SBP_READ = 2'b01,
    SBP_PASSED = 2'b11
  } sbp_state_t;

  // Pin-side outputs of the PROM
  typedef struct packed {
    logic data;
    logic data_oe_n;
    logic chain_select_out_n;
    logic standby;
  } sbp_pins_t;

  // Idle pin levels: data floated, chain-select high
  localparam sbp_pins_t PINS_IDLE = '{
    data: 1'b0,
    data_oe_n: 1'b1,
    chain_select_out_n: 1'b1,
    standby: 1'b1
  };

endpackage

// [rtl/sbp_fifo.sv]
// Word FIFO between the storage array and the bit serialiser
`timescale 1ns/10ps
module sbp_fifo #(
  parameter int WIDTH = sbp_pkg::WORD_W,
  parameter int DEPTH = sbp_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic [WIDTH-1:0] head;
    logic head_vld;
  } sbp_fifo_st_t;

  sbp_fifo_st_t st_ff;
  sbp_fifo_st_t nxt_st;
  logic push;
  logic pop;

  // Head word sits in a register so readers see a flop
  assign in_ready = (st_ff.cnt != CNT_FULL) && !flush;
  assign out_valid = st_ff.head_vld;
  assign out_data = st_ff.head;

  always_comb
  begin
    nxt_st = st_ff;
    push = in_valid && in_ready;
    pop = st_ff.head_vld && out_ready;
    if (pop)
    begin
      nxt_st.head_vld = 1'b0;
    end
    if (push)
    begin
      nxt_st.mem[st_ff.wr] = in_data;
      nxt_st.wr = (st_ff.wr == PTR_LAST) ? '0 : PW'(st_ff.wr + 1'b1);
    end
    // Refill the head register from the array
    if ((!st_ff.head_vld || pop) && st_ff.cnt != '0)
    begin
      nxt_st.head = st_ff.mem[st_ff.rd];
      nxt_st.head_vld = 1'b1;
      nxt_st.rd = (st_ff.rd == PTR_LAST) ? '0 : PW'(st_ff.rd + 1'b1);
      nxt_st.cnt = push ? st_ff.cnt : CW'(st_ff.cnt - 1'b1);
    end
    else if (push)
    begin
      nxt_st.cnt = CW'(st_ff.cnt + 1'b1);
    end
    // Flush drops everything, array contents need no clearing
    if (flush)
    begin
      nxt_st.wr = '0;
      nxt_st.rd = '0;
      nxt_st.cnt = '0;
      nxt_st.head_vld = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule

// [rtl/sbp_prom.sv]
// Read side of the serial boot PROM with cascade chain-select
// Behaviour
// - After last bit, chain-select low, data floats
// - Downstream PROM drives data on low chain-select
// - Inverted-polarity low reset clears address counter
// - Grounded gate input with non-inverted polarity keeps counter after configuration
// - Chip enable high: standby, data always floats
// - Counter advances only with both enables active
// - Reset level clears counter, floats data, programmable
// - Chain-select low when enabled past count limit
`timescale 1ns/10ps
module sbp_prom #(
  parameter int WORD_W = sbp_pkg::WORD_W,
  parameter int NUM_WORDS = sbp_pkg::NUM_WORDS,
  parameter int FIFO_DEPTH = sbp_pkg::FIFO_DEPTH,
  parameter logic [NUM_WORDS*WORD_W-1:0] IMAGE = '0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic config_clock,
  input wire logic chip_en_n,
  input wire logic reset_oe,
  input wire logic reset_pol_inv,
  output sbp_pkg::sbp_pins_t pins,
  output logic [$clog2(NUM_WORDS*WORD_W)-1:0] bit_addr
);
  // Derived sizes; the limit is the address of the last stored bit
  localparam int TOTAL_BITS = NUM_WORDS * WORD_W;
  localparam int AW = $clog2(TOTAL_BITS);
  localparam int FW = $clog2(NUM_WORDS + 1);
  localparam int BW = $clog2(WORD_W);
  localparam logic [AW-1:0] COUNT_LIMIT = AW'(TOTAL_BITS - 1);
  localparam logic [FW-1:0] FETCH_END = FW'(NUM_WORDS);
  localparam logic [BW-1:0] BIT_LAST = BW'(WORD_W - 1);

  // All block state outside the FIFO in one registered word
  typedef struct packed {
    sbp_pkg::sbp_state_t state;
    logic [AW-1:0] addr;
    logic [FW-1:0] fetch;
    logic [WORD_W-1:0] word;
    logic [BW-1:0] bit_idx;
    logic word_vld;
    logic clk_q;
    sbp_pkg::sbp_pins_t pins;
  } sbp_prom_st_t;

  // Reset image: counter cleared, data floated, chain-select high
  localparam sbp_prom_st_t ST_RESET = '{
    state: sbp_pkg::SBP_CLEAR,
    addr: '0,
    fetch: '0,
    word: '0,
    bit_idx: '0,
    word_vld: 1'b0,
    clk_q: 1'b0,
    pins: sbp_pkg::PINS_IDLE
  };

  sbp_prom_st_t st_ff;
  sbp_prom_st_t nxt_st;
  // Decoded pins and handshake nets
  logic clear_lvl;
  logic ce_act;
  logic oe_act;
  logic clk_rise;
  logic fetch_valid;
  logic fetch_ready;
  logic [WORD_W-1:0] fetch_word;
  logic head_valid;
  logic head_take;
  logic [WORD_W-1:0] head_word;
  logic bit_step;
  logic word_done;
  logic at_limit;
  logic drive_ok;
  logic handed_over;

  // Gate pin polarity chosen by the option strap
  assign clear_lvl = (reset_pol_inv == sbp_pkg::POL_LOW_CLEARS) ?
                     !reset_oe : reset_oe;
  assign oe_act = !clear_lvl;
  assign ce_act = !chip_en_n;
  // Host clock is sampled in the mclk domain and edge-detected
  assign clk_rise = config_clock && !st_ff.clk_q;

  // Prefetch words from the array, stalled by a full FIFO
  assign fetch_valid = (st_ff.fetch != FETCH_END) && !clear_lvl;
  assign head_take = !st_ff.word_vld && head_valid && !clear_lvl;

  // Image slice; past the end the index would leave the vector
  always_comb
  begin
    if (st_ff.fetch < FETCH_END)
    begin
      fetch_word = IMAGE[st_ff.fetch * WORD_W +: WORD_W];
    end
    else
    begin
      fetch_word = '0;
    end
  end

  // Serial step: one bit per host rise with both enables and a loaded word
  assign bit_step = clk_rise && ce_act && oe_act && st_ff.word_vld;
  assign word_done = (st_ff.bit_idx == BIT_LAST);
  assign at_limit = (st_ff.addr == COUNT_LIMIT);
  // Data may drive only while reading with both enables active
  assign drive_ok = ce_act && oe_act && st_ff.word_vld &&
                    (st_ff.state == sbp_pkg::SBP_READ);
  // Past the limit the chain-select hands the chip enable on
  assign handed_over = ce_act && oe_act &&
                       (st_ff.state == sbp_pkg::SBP_PASSED);

  // Buffer between array and serialiser; the host never waits on it
  sbp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(clear_lvl),
    .in_valid(fetch_valid),
    .in_data(fetch_word),
    .in_ready(fetch_ready),
    .out_valid(head_valid),
    .out_data(head_word),
    .out_ready(head_take)
  );

  // Outputs come straight from the state register
  assign pins = st_ff.pins;
  assign bit_addr = st_ff.addr;

  // Sequencer, counter and pin outputs
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.clk_q = config_clock;
    if (fetch_valid && fetch_ready)
    begin
      nxt_st.fetch = FW'(st_ff.fetch + 1'b1);
    end
    if (head_take)
    begin
      nxt_st.word = head_word;
      nxt_st.bit_idx = '0;
      nxt_st.word_vld = 1'b1;
    end
    case (st_ff.state)
      sbp_pkg::SBP_CLEAR:
      begin
        // Gate released: counting starts again from bit zero
        if (oe_act)
        begin
          nxt_st.state = sbp_pkg::SBP_READ;
        end
      end
      sbp_pkg::SBP_READ:
      begin
        // A starved serialiser holds the count rather than skip bits
        if (bit_step)
        begin
          // Parks at the limit; the handover shows one cycle later
          if (at_limit)
          begin
            nxt_st.state = sbp_pkg::SBP_PASSED;
          end
          else
          begin
            nxt_st.addr = AW'(st_ff.addr + 1'b1);
          end
          nxt_st.bit_idx = BW'(st_ff.bit_idx + 1'b1);
          if (word_done)
          begin
            nxt_st.word_vld = 1'b0;
          end
        end
      end
      sbp_pkg::SBP_PASSED:
      begin
        // Terminal until a clear; later rises are ignored
        nxt_st.state = sbp_pkg::SBP_PASSED;
      end
      default:
      begin
        nxt_st.state = sbp_pkg::SBP_PASSED;
      end
    endcase
    // Clear level wins over everything; grounded gate clears only under inverted polarity
    if (clear_lvl)
    begin
      nxt_st.state = sbp_pkg::SBP_CLEAR;
      nxt_st.addr = '0;
      nxt_st.fetch = '0;
      nxt_st.word_vld = 1'b0;
    end
    // Data drives only when both enables active and unread bits remain
    nxt_st.pins.data = st_ff.word[st_ff.bit_idx];
    nxt_st.pins.data_oe_n = !drive_ok;
    // Past the limit the chain-select follows the chip enable
    nxt_st.pins.chain_select_out_n = !handed_over;
    nxt_st.pins.standby = !ce_act;
  end

  // Synchronous reset restores the idle image
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_ff <= ST_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule

// [test/sbp_prom_monitor.sv]
// Checker on the serial boot PROM pins, bound into the sbp_prom module
`timescale 1ns/10ps
module sbp_prom_monitor #(
  parameter int NUM_WORDS = 64,
  parameter int WORD_W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic config_clock,
  input wire logic chip_en_n,
  input wire logic reset_oe,
  input wire logic reset_pol_inv,
  input wire sbp_pkg::sbp_pins_t pins,
  input wire logic [$clog2(NUM_WORDS*WORD_W)-1:0] bit_addr
);
  localparam int AW = $clog2(NUM_WORDS*WORD_W);
  localparam logic [AW-1:0] LAST = AW'(NUM_WORDS*WORD_W-1);
  logic clr;
  logic en;
  // Clear level under either polarity; both enables active
  assign clr = reset_oe ^ reset_pol_inv;
  assign en = !chip_en_n && !clr;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_std;
    chip_en_n |=> pins.standby && pins.data_oe_n;
  endproperty
  property p_clr;
    clr |=> bit_addr == '0 && pins.data_oe_n && pins.chain_select_out_n;
  endproperty
  // Three cycles cover either lag from sample to counter update
  property p_idle;
    (!en) [*3] |-> $stable(bit_addr) || bit_addr == '0;
  endproperty
  property p_inc;
    $changed(bit_addr) && bit_addr != '0 |-> bit_addr == $past(bit_addr) + 1'b1;
  endproperty
  property p_en;
    !pins.data_oe_n |-> $past(en);
  endproperty
  property p_fall;
    $fell(pins.chain_select_out_n) |-> pins.data_oe_n && $past(en);
  endproperty
  property p_hold;
    (!clr) [*3] |-> bit_addr >= $past(bit_addr) || $past(bit_addr) == LAST;
  endproperty
  property p_last;
    config_clock && !$past(config_clock) && en && bit_addr == LAST ##1
      en [*2] |=> !pins.chain_select_out_n && pins.data_oe_n;
  endproperty
  a_std: assert property (p_std) else $error("data not floated");
  a_clr: assert property (p_clr) else $error("clear ignored");
  a_idle: assert property (p_idle) else $error("counter moved");
  a_inc: assert property (p_inc) else $error("address skipped");
  a_en: assert property (p_en) else $error("data driven");
  a_fall: assert property (p_fall) else $error("early handover");
  a_hold: assert property (p_hold) else $error("counter lost");
  a_last: assert property (p_last) else $error("no handover");
  c_clr: cover property (clr);
  c_pass: cover property ($fell(pins.chain_select_out_n));
  c_std: cover property (chip_en_n ##1 !chip_en_n);
endmodule

bind sbp_prom sbp_prom_monitor #(.NUM_WORDS(NUM_WORDS), .WORD_W(WORD_W))
  u_mon (.mclk(mclk), .sys_rst(sys_rst), .config_clock(config_clock),
  .chip_en_n(chip_en_n), .reset_oe(reset_oe),
  .reset_pol_inv(reset_pol_inv), .pins(pins), .bit_addr(bit_addr));

// [test/sbp_host_model.sv]
// Host in master serial mode: makes the clock and takes the bits
`timescale 1ns/10ps
module sbp_host_model (
  input wire logic mclk,
  input wire sbp_pkg::sbp_pins_t pins,
  output logic config_clock
);
  // Clock stands low between frames
  initial config_clock = 1'b0;
  // Data pin is only read, never driven back
  // Bit taken before each rise; a floated line reads the pull-up level
  task automatic read_bits(input int n, output logic [31:0] bits);
    bits = '0;
    for (int i = 0; i < n; i++)
    begin
      repeat (3) @(posedge mclk);
      #1;
      bits[i] = pins.data_oe_n ? 1'b1 : pins.data;
      config_clock = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      config_clock = 1'b0;
    end
  endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the serial boot PROM read logic
`timescale 1ns/10ps
module testbench;
  localparam logic [23:0] IMG = 24'hc3_96a5;
  logic mclk;
  logic sys_rst;
  logic config_clock;
  logic chip_en_n;
  logic reset_oe;
  logic reset_pol_inv;
  sbp_pkg::sbp_pins_t pins;
  logic [4:0] bit_addr;
  logic [31:0] got;
  int num_errors;
  int n_checks;

  sbp_prom #(.NUM_WORDS(3), .IMAGE(IMG)) i_sbp_prom (.mclk(mclk),
    .sys_rst(sys_rst), .config_clock(config_clock), .chip_en_n(chip_en_n),
    .reset_oe(reset_oe), .reset_pol_inv(reset_pol_inv), .pins(pins),
    .bit_addr(bit_addr));
  sbp_host_model u_host (.mclk(mclk), .pins(pins),
    .config_clock(config_clock));

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Whole image in order, then handover down the chain
  task automatic t_stream();
    u_host.read_bits(24, got);
    chk("stream", {8'h00, IMG}, got);
    tick(3);
    chk("cso_n", 32'h0, pins.chain_select_out_n);
    chk("oe_n", 32'h1, pins.data_oe_n);
  endtask
  // Once passed, chain-select tracks the select input
  task automatic t_follow();
    chip_en_n = 1'b1;
    tick(2);
    chk("standby", 32'h1, pins.standby);
    chk("cso_n", 32'h1, pins.chain_select_out_n);
    chip_en_n = 1'b0;
    tick(2);
    chk("cso_n", 32'h0, pins.chain_select_out_n);
  endtask
  // Low gate under inverted polarity restarts at bit zero
  task automatic t_clear();
    reset_oe = 1'b0;
    tick(3);
    chk("addr", 32'h0, bit_addr);
    chk("cso_n", 32'h1, pins.chain_select_out_n);
    reset_oe = 1'b1;
    tick(6);
    u_host.read_bits(4, got);
    chk("restart", IMG[3:0], got);
    // Abort in mid-stream: the gate alone must pull the count back
    reset_oe = 1'b0;
    tick(3);
    chk("abort", 32'h0, bit_addr);
    chk("abort_oe_n", 32'h1, pins.data_oe_n);
    reset_oe = 1'b1;
    tick(6);
    u_host.read_bits(4, got);
    chk("reload", IMG[3:0], got);
  endtask
  // Grounded gate keeps the count across a deselect
  task automatic t_hold();
    reset_pol_inv = 1'b0;
    reset_oe = 1'b0;
    chip_en_n = 1'b1;
    u_host.read_bits(2, got);
    chk("floated", 32'h3, got);
    chk("addr", 32'h4, bit_addr);
    chip_en_n = 1'b0;
    tick(6);
    u_host.read_bits(4, got);
    chk("resume", IMG[7:4], got);
    tick(3);
    chk("addr", 32'h8, bit_addr);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    num_errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    chip_en_n = 1'b0;
    reset_oe = 1'b1;
    reset_pol_inv = 1'b1;
    tick(16);
    sys_rst = 1'b0;
    tick(6);
    t_stream();
    t_follow();
    t_clear();
    t_hold();
    tally_and_finish();
  end
  // Watchdog: about 10000 cycles, far beyond the few hundred needed
  initial
  begin
    #40000;
    num_errors++;
    tally_and_finish();
  end
endmodule
